// >>> hdl/dcol_offset_loop.sv
`timescale 1ns/10ps
module dcol_offset_loop #(
	parameter int W = dcol_pkg::SAMPLE_W
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	// Control
	input  wire logic                enable,
	input  wire logic [3:0]          tc_code,
	// Sample in, estimate out
	input  wire logic signed [W-1:0] sample,
	output logic signed [W-1:0]      est
);
	import dcol_pkg::*;

	localparam int ACC_W = W + TC_BASE_LOG2 + int'(TC_MAX_CODE) + 1;
	localparam logic signed [ACC_W-1:0] LIM = ACC_W'(OFFSET_LIMIT_LSB);

	logic signed [ACC_W-1:0] acc;
	logic signed [ACC_W-1:0] next_acc;
	logic signed [ACC_W-1:0] shifted;
	logic signed [W:0]       diff;
	logic [4:0]              shift;

	// ------------------------------------------------------------
	// Leaky integrator, time constant 2^shift cycles
	// ------------------------------------------------------------
	always_comb begin
		shift = 5'(TC_BASE_LOG2) + {1'b0, (tc_code > TC_MAX_CODE) ? TC_MAX_CODE : tc_code};
		diff = {sample[W-1], sample} - {est[W-1], est};
		next_acc = acc + {{(ACC_W-W-1){diff[W]}}, diff};
		shifted = next_acc >>> shift;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= '0;
			est <= '0;
		end else if (ce && enable) begin
			acc <= next_acc;
			if (shifted > LIM)
				est <= W'(LIM);
			else if (shifted < -LIM)
				est <= W'(-LIM);
			else
				est <= shifted[W-1:0];
		end
	end

	est_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		(est <= W'(LIM)) && (est >= W'(-LIM)))
		else $error("offset estimate out of range");

	est_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!enable |=> $stable(est))
		else $error("estimate moved while frozen");

endmodule // dcol_offset_loop

// >>> hdl/dcol_pkg.sv
package dcol_pkg;

	// ------------------------------------------------------------
	// Widths and register map
	// ------------------------------------------------------------
	localparam int          SAMPLE_W     = 14;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_EST_A    = 8'h08;
	localparam logic [7:0]  REG_EST_B    = 8'h0C;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

	// Control fields
	localparam int          CTRL_OC_EN   = 0;
	localparam int          CTRL_TC_LSB  = 4;
	localparam int          CTRL_PWR_LSB = 8;
	localparam int          CTRL_PIN_SEL = 12;

	// Status fields
	localparam int          ST_STATE_A   = 0;
	localparam int          ST_STATE_B   = 2;
	localparam int          ST_LOW_RATE  = 4;
	localparam int          ST_REF_ON    = 5;
	localparam int          ST_MUX       = 6;
	localparam int          ST_CODE_LSB  = 8;

	// ------------------------------------------------------------
	// Offset loop
	// ------------------------------------------------------------
	localparam int          TC_BASE_LOG2 = 18;
	localparam logic [3:0]  TC_MAX_CODE  = 4'hB;
	localparam int          FULL_SCALE_UV    = 2000000;
	localparam int          OFFSET_LIMIT_UV  = 10000;
	localparam int          OFFSET_LIMIT_LSB = OFFSET_LIMIT_UV * (2 ** SAMPLE_W) / FULL_SCALE_UV;

	// ------------------------------------------------------------
	// Power-state codes
	// ------------------------------------------------------------
	localparam logic [3:0]  PWR_NORMAL     = 4'h0;
	localparam logic [3:0]  PWR_LAST_SPARE = 4'h8;
	localparam logic [3:0]  PWR_OBUF_B_OFF = 4'h9;
	localparam logic [3:0]  PWR_OBUF_A_OFF = 4'hA;
	localparam logic [3:0]  PWR_OBUF_OFF   = 4'hB;
	localparam logic [3:0]  PWR_GLOBAL     = 4'hC;
	localparam logic [3:0]  PWR_STBY_B     = 4'hD;
	localparam logic [3:0]  PWR_STBY_A     = 4'hE;
	localparam logic [3:0]  PWR_MUX        = 4'hF;
	localparam logic        PIN_PREFIX     = 1'b1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          PCLK_PERIOD_NS  = 100;
	localparam int          GLOBAL_WAKE_NS  = 30000;
	localparam int          STBY_WAKE_NS    = 1000;
	localparam int          GLOBAL_WAKE_CYC = (GLOBAL_WAKE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam int          STBY_WAKE_CYC   = (STBY_WAKE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam int          WAKE_W          = $clog2(GLOBAL_WAKE_CYC + 1);
	localparam int          MIN_RATE_SPS    = 1000000;

	typedef enum logic [1:0] {
		CH_OFF  = 2'b00,
		CH_WAKE = 2'b01,
		CH_ON   = 2'b11
	} dcol_chan_type;

endpackage

// >>> hdl/dcol_rate_monitor.sv
`timescale 1ns/10ps
module dcol_rate_monitor #(
	parameter int MIN_CYC = 10
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Reference tick pin
	input  wire logic rate_ref,
	// Low-rate flag
	output logic      low_rate
);
	import dcol_pkg::*;

	localparam int CW = $clog2(MIN_CYC + 1);

	logic          ref_meta;
	logic          ref_sync;
	logic          ref_prev;
	logic [CW-1:0] cnt;

	// ------------------------------------------------------------
	// Count sampling clocks per reference period
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_meta <= 1'b0;
			ref_sync <= 1'b0;
			ref_prev <= 1'b0;
			cnt      <= '0;
			low_rate <= 1'b0;
		end else if (ce) begin
			ref_meta <= rate_ref;
			ref_sync <= ref_meta;
			ref_prev <= ref_sync;
			if (ref_sync && !ref_prev) begin
				low_rate <= (cnt < CW'(MIN_CYC));
				cnt      <= '0;
			end else if (cnt != CW'(MIN_CYC)) begin
				cnt <= cnt + 1'b1;
			end
		end
	end

endmodule // dcol_rate_monitor

// >>> hdl/dcol_top.sv
`timescale 1ns/10ps
module dcol_top #(
	parameter int REF_HZ = 100000
) (
	// Clock, reset, enable
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         ce,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [dcol_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [dcol_pkg::DATA_W-1:0]  pwdata,
	output logic      [dcol_pkg::DATA_W-1:0]  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Mode pins and rate reference
	input  wire logic                         mode_pin_first,
	input  wire logic                         mode_pin_second,
	input  wire logic                         mode_pin_third,
	input  wire logic                         rate_ref,
	// Converter samples
	input  wire logic [dcol_pkg::SAMPLE_W-1:0] raw_a,
	input  wire logic [dcol_pkg::SAMPLE_W-1:0] raw_b,
	// Output buses
	output logic      [dcol_pkg::SAMPLE_W-1:0] chan_a_output_bus,
	output logic                              chan_a_output_oe,
	output logic      [dcol_pkg::SAMPLE_W-1:0] chan_b_output_bus,
	output logic                              chan_b_output_oe,
	output logic                              clk_out_oe,
	output logic                              mux_chan_b,
	// Power and status
	output logic                              chan_a_valid,
	output logic                              chan_b_valid,
	output logic                              conv_a_power,
	output logic                              conv_b_power,
	output logic                              ref_power,
	output logic                              low_power
);
	import dcol_pkg::*;

	localparam int MIN_CYC = MIN_RATE_SPS / REF_HZ;
	localparam int SW      = SAMPLE_W;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [SW-1:0] sat_sub(input logic [SW-1:0] a, input logic [SW-1:0] b);
		logic signed [SW:0] d;
		d = $signed({a[SW-1], a}) - $signed({b[SW-1], b});
		if (d[SW] != d[SW-1])
			sat_sub = d[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
		else
			sat_sub = d[SW-1:0];
	endfunction

	function automatic logic [3:0] norm_code(input logic [3:0] c);
		norm_code = (c <= PWR_LAST_SPARE) ? PWR_NORMAL : c;
	endfunction

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                oc_en;
	logic [3:0]          tc_code;
	logic [3:0]          pwr_field;
	logic                pin_sel;
	logic [2:0]          pin_meta;
	logic [2:0]          pin_sync;
	logic [3:0]          sel_code;
	logic [3:0]          eff_code;
	logic                glob;
	logic                mux_mode;
	logic [1:0]          stby;
	logic [1:0]          obuf_off;
	logic [1:0]          pwr_on;
	logic                low_rate;
	dcol_chan_type       chan_state [2];
	logic [WAKE_W-1:0]   wake_cnt [2];
	logic [1:0]          valid;
	logic [1:0]          conv_on;
	logic [SW-1:0]       raw [2];
	logic [SW-1:0]       est [2];
	logic [SW-1:0]       corr [2];
	logic                wr_access;
	logic                addr_hit;
	logic [DATA_W-1:0]   read_mux;

	assign raw[0] = raw_a;
	assign raw[1] = raw_b;

	// ------------------------------------------------------------
	// APB register file
	// ------------------------------------------------------------
	assign wr_access = psel && penable && pready && pwrite && ce;
	assign addr_hit  = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
		(paddr == REG_EST_A) || (paddr == REG_EST_B);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_en     <= CTRL_RESET[CTRL_OC_EN];
			tc_code   <= CTRL_RESET[CTRL_TC_LSB +: 4];
			pwr_field <= CTRL_RESET[CTRL_PWR_LSB +: 4];
			pin_sel   <= CTRL_RESET[CTRL_PIN_SEL];
		end else if (wr_access && paddr == REG_CTRL) begin
			oc_en     <= pwdata[CTRL_OC_EN];
			tc_code   <= pwdata[CTRL_TC_LSB +: 4];
			pwr_field <= pwdata[CTRL_PWR_LSB +: 4];
			pin_sel   <= pwdata[CTRL_PIN_SEL];
		end
	end

	always_comb begin
		read_mux = '0;
		unique case (paddr)
			REG_CTRL: begin
				read_mux[CTRL_OC_EN]         = oc_en;
				read_mux[CTRL_TC_LSB +: 4]   = tc_code;
				read_mux[CTRL_PWR_LSB +: 4]  = pwr_field;
				read_mux[CTRL_PIN_SEL]       = pin_sel;
			end
			REG_STATUS: begin
				read_mux[ST_STATE_A +: 2]    = chan_state[0];
				read_mux[ST_STATE_B +: 2]    = chan_state[1];
				read_mux[ST_LOW_RATE]        = low_rate;
				read_mux[ST_REF_ON]          = ref_power;
				read_mux[ST_MUX]             = mux_mode;
				read_mux[ST_CODE_LSB +: 4]   = eff_code;
			end
			REG_EST_A: read_mux = {{(DATA_W-SW){est[0][SW-1]}}, est[0]};
			REG_EST_B: read_mux = {{(DATA_W-SW){est[1][SW-1]}}, est[1]};
			default:   read_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready <= ce;
			if (ce && psel) begin
				prdata  <= read_mux;
				pslverr <= !addr_hit;
			end
		end
	end

	// ------------------------------------------------------------
	// Mode pins and power-state decode
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else if (ce) begin
			pin_meta <= {mode_pin_first, mode_pin_second, mode_pin_third};
			pin_sync <= pin_meta;
		end
	end

	always_comb begin
		if (pin_sel)
			sel_code = (pin_sync == 3'h0) ? PWR_NORMAL : {PIN_PREFIX, pin_sync};
		else
			sel_code = pwr_field;
		eff_code    = norm_code(sel_code);
		glob        = (eff_code == PWR_GLOBAL);
		mux_mode    = (eff_code == PWR_MUX);
		stby[0]     = (eff_code == PWR_STBY_A);
		stby[1]     = (eff_code == PWR_STBY_B);
		obuf_off[0] = (eff_code == PWR_OBUF_A_OFF) || (eff_code == PWR_OBUF_OFF);
		obuf_off[1] = (eff_code == PWR_OBUF_B_OFF) || (eff_code == PWR_OBUF_OFF);
		pwr_on[0]   = !glob && !stby[0] && !low_rate;
		pwr_on[1]   = !glob && !stby[1] && !low_rate;
	end

	dcol_rate_monitor #(
		.MIN_CYC (MIN_CYC)
	) u_rate (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.rate_ref (rate_ref),
		.low_rate (low_rate)
	);

	// ------------------------------------------------------------
	// Power sequencing per channel
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_power <= 1'b0;
			low_power <= 1'b0;
		end else if (ce) begin
			ref_power <= !glob;
			low_power <= low_rate;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				chan_state[i] <= CH_OFF;
				wake_cnt[i]   <= '0;
				conv_on[i]    <= 1'b0;
			end
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				conv_on[i] <= pwr_on[i];
				unique case (chan_state[i])
					CH_OFF: begin
						if (pwr_on[i]) begin
							chan_state[i] <= CH_WAKE;
							wake_cnt[i]   <= ref_power ? WAKE_W'(STBY_WAKE_CYC)
								: WAKE_W'(GLOBAL_WAKE_CYC);
						end
					end
					CH_WAKE: begin
						if (!pwr_on[i])
							chan_state[i] <= CH_OFF;
						else if (wake_cnt[i] == WAKE_W'(1))
							chan_state[i] <= CH_ON;
						else
							wake_cnt[i] <= wake_cnt[i] - 1'b1;
					end
					CH_ON: begin
						if (!pwr_on[i])
							chan_state[i] <= CH_OFF;
					end
					default: chan_state[i] <= CH_OFF;
				endcase
			end
		end
	end

	assign valid[0]     = chan_state[0][1];
	assign valid[1]     = chan_state[1][1];
	assign chan_a_valid = valid[0];
	assign chan_b_valid = valid[1];
	assign conv_a_power = conv_on[0];
	assign conv_b_power = conv_on[1];

	// ------------------------------------------------------------
	// Offset loops and correction
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_loop
		dcol_offset_loop #(
			.W (SW)
		) u_loop (
			.pclk    (pclk),
			.presetn (presetn),
			.ce      (ce),
			.enable  (oc_en && valid[g]),
			.tc_code (tc_code),
			.sample  (raw[g]),
			.est     (est[g])
		);
		assign corr[g] = valid[g] ? sat_sub(raw[g], est[g]) : '0;
	end

	// ------------------------------------------------------------
	// Output buses
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_a_output_bus <= '0;
			chan_b_output_bus <= '0;
			chan_a_output_oe  <= 1'b0;
			chan_b_output_oe  <= 1'b0;
			clk_out_oe        <= 1'b0;
			mux_chan_b        <= 1'b0;
		end else if (ce) begin
			if (glob) begin
				chan_a_output_bus <= '0;
				chan_b_output_bus <= '0;
				chan_a_output_oe  <= 1'b0;
				chan_b_output_oe  <= 1'b0;
				clk_out_oe        <= 1'b0;
				mux_chan_b        <= 1'b0;
			end else if (mux_mode) begin
				chan_a_output_bus <= mux_chan_b ? corr[0] : corr[1];
				chan_b_output_bus <= '0;
				chan_a_output_oe  <= 1'b1;
				chan_b_output_oe  <= 1'b0;
				clk_out_oe        <= 1'b1;
				mux_chan_b        <= !mux_chan_b;
			end else begin
				chan_a_output_bus <= corr[0];
				chan_b_output_bus <= corr[1];
				chan_a_output_oe  <= !obuf_off[0];
				chan_b_output_oe  <= !obuf_off[1];
				clk_out_oe        <= 1'b1;
				mux_chan_b        <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic ctrl_en_wr;
	assign ctrl_en_wr = wr_access && (paddr == REG_CTRL) && pwdata[CTRL_OC_EN];

	sequence mux_pair;
		!chan_b_output_oe && mux_chan_b ##1 !chan_b_output_oe && !mux_chan_b;
	endsequence

	oc_stays_off_a: assert property (!oc_en && !ctrl_en_wr |=> !oc_en)
		else $error("offset correction enabled without a write");

	glob_hiz_a: assert property (glob && ce |=>
		!chan_a_output_oe && !chan_b_output_oe && !clk_out_oe)
		else $error("outputs driven in global power down");

	glob_wake_a: assert property ($rose(chan_state[0] == CH_WAKE)
		&& !$past(ref_power) |-> wake_cnt[0] == WAKE_W'(GLOBAL_WAKE_CYC))
		else $error("wrong wake time after global power down");

	stby_wake_a: assert property ($rose(chan_state[1] == CH_WAKE)
		&& $past(ref_power) |-> wake_cnt[1] == WAKE_W'(STBY_WAKE_CYC))
		else $error("wrong wake time after standby");

	stby_b_ref_a: assert property (eff_code == PWR_STBY_B && ce |=>
		!conv_b_power && ref_power && !chan_b_valid)
		else $error("channel B standby wrong");

	obuf_b_off_a: assert property (eff_code == PWR_OBUF_B_OFF && ce |=>
		!chan_b_output_oe && chan_a_output_oe)
		else $error("channel B buffer not disabled");

	mux_interleave_a: assert property (mux_mode && ce && !mux_chan_b
		##1 mux_mode && ce |-> mux_pair)
		else $error("multiplexed output not interleaved");

	pins_normal_a: assert property (pin_sel && pin_sync == 3'h0 |->
		eff_code == PWR_NORMAL)
		else $error("all-low pins not normal");

	spare_normal_a: assert property (!pin_sel && pwr_field <= PWR_LAST_SPARE
		|-> eff_code == PWR_NORMAL && !glob && !mux_mode)
		else $error("spare code not treated as normal");

	wake_to_on_a: assert property (chan_state[0] == CH_WAKE
		&& wake_cnt[0] == WAKE_W'(1) && pwr_on[0] && ce |=> chan_a_valid)
		else $error("channel A did not come up after wake count");

	low_rate_down_a: assert property (low_rate && ce |=>
		!conv_a_power && !conv_b_power && low_power)
		else $error("low rate did not power down converters");

endmodule // dcol_top

// >>> test/dcol_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host controller: APB master and mode pins
// ------------------------------------------------------------
module dcol_host_model (
	// Clock
	input  wire logic        pclk,
	// APB master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// Mode pins
	output logic [2:0]       pins
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pins = 3'h0;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		if (a == 8'h00 && (d[7:4] == 4'hC || d[7:4] == 4'hD)) d[7:4] = 4'hB;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic set_pins(input logic [2:0] p);
		@(posedge pclk);
		pins <= p;
	endtask
endmodule // dcol_host_model

// >>> test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import dcol_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rate_ref, e, k;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d, ea, eb;
	logic [2:0]  pins;
	logic [13:0] raw_a, raw_b, bus_a, bus_b;
	logic        oe_a, oe_b, clk_oe, mux_b, val_a, val_b, pw_a, pw_b, pw_ref, low_pwr;
	logic [5:0]  outs;
	int          fails = 0, checked = 0, seed = 32'h02bc, ref_half = 10, n, c, p;
	assign outs = {oe_a, oe_b, clk_oe, pw_a, pw_b, pw_ref};

	dcol_host_model host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins));
	dcol_top dcol_top_i (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_pin_first(pins[2]),
		.mode_pin_second(pins[1]), .mode_pin_third(pins[0]), .rate_ref(rate_ref),
		.raw_a(raw_a), .raw_b(raw_b), .chan_a_output_bus(bus_a), .chan_a_output_oe(oe_a),
		.chan_b_output_bus(bus_b), .chan_b_output_oe(oe_b), .clk_out_oe(clk_oe),
		.mux_chan_b(mux_b), .chan_a_valid(val_a), .chan_b_valid(val_b),
		.conv_a_power(pw_a), .conv_b_power(pw_b), .ref_power(pw_ref), .low_power(low_pwr));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		host_i.xfer(1'h1, a, v, d, e);
	endtask

	task rd(input logic [7:0] a);
		host_i.xfer(1'h0, a, 32'h0, d, e);
	endtask

	task settle(input int m);
		repeat (m) @(posedge pclk);
		@(negedge pclk);
	endtask

	task wait_valid;
		n = 0;
		while (!(val_a === 1'h1 && val_b === 1'h1) && n < 400) begin
			@(negedge pclk);
			n++;
		end
	endtask

	function automatic logic [13:0] rnd();
		rnd = 14'($random(seed) % 3000);
	endfunction

	// Mask and expected {oe_a, oe_b, clk_oe, conv_a, conv_b, ref}
	function automatic logic [11:0] pexp(input logic [3:0] cd);
		case (cd)
			4'h9: pexp = {6'h3F, 6'h2F};
			4'hA: pexp = {6'h3F, 6'h1F};
			4'hB: pexp = {6'h37, 6'h07};
			4'hD: pexp = {6'h07, 6'h05};
			4'hE: pexp = {6'h07, 6'h03};
			4'hF: pexp = {6'h37, 6'h27};
			default: pexp = {6'h3F, 6'h3F};
		endcase
	endfunction

	task samp(input logic [13:0] a, input logic [13:0] b, input logic [13:0] xa,
			input logic [13:0] xb);
		@(posedge pclk);
		raw_a <= a;
		raw_b <= b;
		settle(1);
		chk(bus_a, 14'(a - xa), "bus a");
		chk(bus_b, 14'(b - xb), "bus b");
	endtask

	task pcheck(input logic [3:0] cd);
		logic [11:0] pe;
		pe = pexp(cd);
		chk(outs & pe[11:6], pe[5:0] & pe[11:6], "power");
	endtask

	// ------------------------------------------------------------
	// Clock, reference tick, watchdog
	// ------------------------------------------------------------
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end

	initial begin
		rate_ref = 1'h0;
		forever begin
			repeat (ref_half) @(posedge pclk);
			rate_ref <= ~rate_ref;
		end
	end

	initial begin
		repeat (50000) @(posedge pclk);
		fails++;
		$display("mismatch at %0t: watchdog", $time);
		give_verdict;
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		presetn = 1'h0;
		raw_a = 14'h0;
		raw_b = 14'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(REG_CTRL);
		chk(d, CTRL_RESET, "ctrl reset");
		rd(8'h40);
		chk(e, 1, "unmapped err");
		chk(d, 0, "unmapped data");
		wait_valid;
		chk(n <= GLOBAL_WAKE_CYC + 5, 1, "first wake");
		$display("test reset done");
		repeat (20) samp(rnd(), rnd(), 14'h0, 14'h0);
		$display("test pass-through done");
		raw_a <= 14'h1FFF;
		raw_b <= 14'h0;
		wr(REG_CTRL, 32'h11);
		repeat (40) @(posedge pclk);
		wr(REG_CTRL, 32'h10);
		rd(REG_EST_A);
		chk(d, 0, "slow tc");
		wr(REG_CTRL, 32'h01);
		repeat (3000) @(posedge pclk);
		rd(REG_EST_A);
		chk(d, OFFSET_LIMIT_LSB, "est a limit");
		rd(REG_EST_B);
		chk(d, 0, "est b");
		samp(14'h100, 14'h0, 14'(OFFSET_LIMIT_LSB), 14'h0);
		wr(REG_CTRL, 32'h0);
		repeat (10) samp(rnd(), 14'h0, 14'(OFFSET_LIMIT_LSB), 14'h0);
		rd(REG_EST_A);
		chk(d, OFFSET_LIMIT_LSB, "frozen");
		$display("test offset done");
		for (c = 0; c < 16; c++) begin
			if (c != 12) begin
				wr(REG_CTRL, 32'(c << 8));
				settle(20);
				pcheck(4'(c));
			end
		end
		wr(REG_CTRL, 32'h1000);
		for (p = 0; p < 8; p++) begin
			if (p != 4) begin
				host_i.set_pins(3'(p));
				settle(20);
				pcheck(p == 0 ? 4'h0 : {1'h1, 3'(p)});
				rd(REG_STATUS);
				chk(d[11:8], p == 0 ? 4'h0 : {1'h1, 3'(p)}, "pin code");
			end
		end
		host_i.set_pins(3'h0);
		$display("test power codes done");
		wr(REG_CTRL, 32'hC00);
		settle(5);
		chk(outs, 6'h00, "global down");
		wr(REG_CTRL, 32'h0);
		wait_valid;
		chk(n >= GLOBAL_WAKE_CYC - 2 && n <= GLOBAL_WAKE_CYC + 5, 1, "slow wake");
		wr(REG_CTRL, 32'hE00);
		settle(5);
		chk(pw_ref, 1, "ref on");
		wr(REG_CTRL, 32'h0);
		wait_valid;
		chk(n >= STBY_WAKE_CYC - 2 && n <= STBY_WAKE_CYC + 5, 1, "fast wake");
		$display("test wake done");
		rd(REG_EST_A);
		ea = d;
		rd(REG_EST_B);
		eb = d;
		raw_a <= 14'd100;
		raw_b <= 14'd200;
		wr(REG_CTRL, 32'hF00);
		settle(5);
		k = mux_b;
		repeat (6) begin
			@(negedge pclk);
			chk(mux_b, !k, "mux turn");
			chk(bus_a, mux_b ? 14'(200 - eb) : 14'(100 - ea), "mux data");
			k = mux_b;
		end
		$display("test mux done");
		ref_half = 2;
		settle(80);
		chk(low_pwr, 1, "low rate");
		ref_half = 10;
		settle(80);
		chk(low_pwr, 0, "rate back");
		$display("test low rate done");
		give_verdict;
	end
endmodule // tb_top
